// File: cfg_protect_pkg.sv
package cfg_protect_pkg;

    // ==========================================
    // Configuration image layout
    localparam int          CFG_WORDS     = 4;
    localparam int          CFG_BITS      = 128;
    localparam int          WORD_W        = 32;
    localparam int          CP_BIT        = 28;
    localparam int          BWP_BIT       = 24;
    localparam int          PWP_LSB       = 12;
    localparam int          PWP_W         = 8;
    localparam int          DEBUG_LSB     = 0;
    localparam logic [1:0]  DEBUG_OFF     = 2'h3;
    localparam logic [7:0]  PWP_NONE      = 8'hFF;
    localparam logic [127:0] CFG_RESET    = {128{1'b1}};

    // ==========================================
    // Memory map
    localparam logic [31:0] PFLASH_BASE   = 32'hBD00_0000;
    localparam logic [31:0] PFLASH_BYTES  = 32'h0008_0000;
    localparam logic [31:0] PAGE_BYTES    = 32'h0000_1000;
    localparam int          PAGE_WORDS    = 1024;
    localparam logic [31:0] BFLASH_BASE   = 32'hBFC0_0000;
    localparam logic [31:0] BFLASH_LAST   = 32'hBFC0_2FFF;

    // Identity word, value arbitrary
    localparam logic [31:0] DEVICE_ID     = 32'h1234_5001;

    // ==========================================
    // Request carriers
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        id_rd;
        logic [31:0] addr;
        logic [31:0] wdata;
    } prog_req_s;

    typedef struct packed {
        logic        wr;
        logic        erase;
        logic [31:0] addr;
    } self_req_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  word;
        logic [31:0] data;
    } cfg_wr_s;

    typedef enum logic [0:0] {
        ST_LOAD = 1'b0,
        ST_RUN  = 1'b1
    } cfg_state_e;

endpackage

// File: cfg_integrity_check.sv
`timescale 1ns/1ns
module cfg_integrity_check
    import cfg_protect_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    input  wire logic                i_enable,
    input  wire logic [CFG_BITS-1:0] i_active,
    input  wire logic [CFG_BITS-1:0] i_shadow,
    output logic                     o_mismatch
);

    // ==========================================
    // Bitwise compare against stored complement
    wire logic [CFG_BITS-1:0] bit_bad;
    wire logic                any_bad;

    assign bit_bad = ~(i_active ^ i_shadow);
    assign any_bad = |bit_bad;

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_mismatch <= 1'b0;
        end else if (i_ce) begin
            o_mismatch <= i_enable & any_bad;
        end
    end

    a_mismatch_flag: assert property (
        @(posedge i_clock) disable iff (i_rst)
        i_ce && i_enable && any_bad |=> o_mismatch)
        else $error("complement mismatch not flagged");

endmodule

// File: cfg_flash_protect.sv
`timescale 1ns/1ns
// Behaviour
// - Each configuration bit programmable once per power
// - Keep inverted shadow, compare all 128 bits
// - Any mismatch raises a whole-device reset
// - Code protect blocks programmer flash access
// - Protected programmer may read only device id
// - Code protect never blocks self-programming
// - Boot write-protect bit blocks boot self-writes
// - Page protect field is word zero 19:12
// - One page is 4096 bytes, 1024 words
// - Protected pages are inverse of field
// - Region runs from base through last page
// - Region limited by implemented program flash
// - Every reset reloads configuration from boot image
// - Unprogrammed bits read one; only one-to-zero
// - Code protect forces debugger field to 11
module cfg_flash_protect
    import cfg_protect_pkg::*;
(
    input  wire logic                i_clock,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    input  wire logic                i_power_on,
    input  wire logic [CFG_BITS-1:0] i_stored_cfg,
    input  wire cfg_wr_s             i_cfg_wr,
    input  wire prog_req_s           i_prog,
    input  wire logic [WORD_W-1:0]   i_flash_rdata,
    input  wire self_req_s           i_self,
    output logic [CFG_BITS-1:0]      o_cfg_active,
    output logic                     o_cfg_ready,
    output logic                     o_cfg_mismatch_rst,
    output logic [1:0]               o_debug_en,
    output logic                     o_prog_flash_rd,
    output logic                     o_prog_flash_wr,
    output logic                     o_prog_denied,
    output logic [WORD_W-1:0]        o_prog_rdata,
    output logic                     o_prog_rvalid,
    output logic [WORD_W-1:0]        o_flash_addr,
    output logic [WORD_W-1:0]        o_flash_wdata,
    output logic                     o_self_flash_wr,
    output logic                     o_self_flash_erase,
    output logic                     o_self_blocked
);

    // ==========================================
    // Helper functions
    function automatic logic in_range(input logic [31:0] addr,
                                      input logic [31:0] lo,
                                      input logic [31:0] last);
        in_range = (addr >= lo) && (addr <= last);
    endfunction

    function automatic logic [31:0] pwp_bytes(input logic [7:0] field);
        logic [31:0] pages;
        logic [31:0] bytes;
        pages = {24'h00_0000, ~field};
        bytes = pages * PAGE_BYTES;
        if (bytes > PFLASH_BYTES) begin
            bytes = PFLASH_BYTES;
        end
        pwp_bytes = bytes;
    endfunction

    // ==========================================
    // State
    cfg_state_e            state;
    logic [CFG_BITS-1:0]   cfg_active;
    logic [CFG_BITS-1:0]   cfg_shadow;
    logic [CFG_BITS-1:0]   cfg_locked;

    // ==========================================
    // Decoded configuration
    wire logic [WORD_W-1:0] word_zero;
    wire logic              code_read_protect;
    wire logic              boot_write_protect;
    wire logic [PWP_W-1:0]  page_write_protect_count;
    wire logic [31:0]       pwp_size;
    wire logic [31:0]       pwp_last;
    wire logic              pwp_enabled;
    wire logic              running;

    assign word_zero                = cfg_active[WORD_W-1:0];
    assign code_read_protect        = ~word_zero[CP_BIT];
    assign boot_write_protect       = ~word_zero[BWP_BIT];
    assign page_write_protect_count =
        word_zero[PWP_LSB +: PWP_W];
    assign pwp_size    = pwp_bytes(page_write_protect_count);
    assign pwp_enabled = (pwp_size != 32'h0000_0000);
    assign pwp_last    = PFLASH_BASE + pwp_size - 32'h0000_0001;
    assign running     = (state == ST_RUN);

    // ==========================================
    // Configuration write path
    wire logic [CFG_BITS-1:0] wr_mask;
    wire logic [CFG_BITS-1:0] wr_zero;
    wire logic [CFG_BITS-1:0] next_active;
    wire logic [CFG_BITS-1:0] next_locked;
    wire logic                cfg_write;

    assign cfg_write = running & i_cfg_wr.valid;
    assign wr_mask   = {{(CFG_BITS-WORD_W){1'b0}}, {WORD_W{1'b1}}}
                       << ({5'h00, i_cfg_wr.word} * 7'h20);
    assign wr_zero   = {{(CFG_BITS-WORD_W){1'b0}}, ~i_cfg_wr.data}
                       << ({5'h00, i_cfg_wr.word} * 7'h20);
    // Only unlocked bits may drop to zero
    assign next_active = cfg_active
                         & ~(wr_zero & wr_mask & ~cfg_locked);
    assign next_locked = cfg_locked | (wr_zero & wr_mask);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            state      <= ST_LOAD;
            cfg_active <= CFG_RESET;
            cfg_shadow <= ~CFG_RESET;
        end else if (i_ce) begin
            if (state == ST_LOAD) begin
                state      <= ST_RUN;
                cfg_active <= i_stored_cfg;
                cfg_shadow <= ~i_stored_cfg;
            end else if (cfg_write) begin
                cfg_active <= next_active;
                cfg_shadow <= ~next_active;
            end
        end
    end

    // Locks survive ordinary resets, cleared by power-on only
    always_ff @(posedge i_clock) begin
        if (i_power_on) begin
            cfg_locked <= {CFG_BITS{1'b0}};
        end else if (i_ce && cfg_write) begin
            cfg_locked <= next_locked;
        end
    end

    cfg_integrity_check u_check (
        .i_clock    (i_clock),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_enable   (running),
        .i_active   (cfg_active),
        .i_shadow   (cfg_shadow),
        .o_mismatch (o_cfg_mismatch_rst)
    );

    // ==========================================
    // External programmer gating
    wire logic prog_rd_ok;
    wire logic prog_wr_ok;
    wire logic prog_deny;

    assign prog_rd_ok = running & i_prog.rd & ~i_prog.id_rd
                        & ~code_read_protect;
    assign prog_wr_ok = running & i_prog.wr & ~code_read_protect;
    assign prog_deny  = running & code_read_protect
                        & ((i_prog.rd & ~i_prog.id_rd) | i_prog.wr);

    // ==========================================
    // Self-programming gating
    wire logic self_req;
    wire logic self_in_boot;
    wire logic self_in_pwp;
    wire logic self_block;

    assign self_req     = running & (i_self.wr | i_self.erase);
    assign self_in_boot = in_range(i_self.addr, BFLASH_BASE, BFLASH_LAST);
    assign self_in_pwp  = pwp_enabled
                          & in_range(i_self.addr, PFLASH_BASE, pwp_last);
    // Code protect is deliberately absent here
    assign self_block   = (self_in_boot & boot_write_protect)
                          | self_in_pwp;

    // ==========================================
    // Registered outputs, then combinational cfg, ready and debug outputs
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_prog_flash_rd    <= 1'b0;
            o_prog_flash_wr    <= 1'b0;
            o_prog_denied      <= 1'b0;
            o_prog_rvalid      <= 1'b0;
            o_prog_rdata       <= 32'h0000_0000;
            o_flash_addr       <= 32'h0000_0000;
            o_flash_wdata      <= 32'h0000_0000;
            o_self_flash_wr    <= 1'b0;
            o_self_flash_erase <= 1'b0;
            o_self_blocked     <= 1'b0;
        end else if (i_ce) begin
            o_prog_flash_rd    <= prog_rd_ok;
            o_prog_flash_wr    <= prog_wr_ok;
            o_prog_denied      <= prog_deny;
            o_prog_rvalid      <= running & i_prog.rd;
            if (running && i_prog.rd) begin
                if (i_prog.id_rd) begin
                    o_prog_rdata <= DEVICE_ID;
                end else if (code_read_protect) begin
                    o_prog_rdata <= 32'h0000_0000;
                end else begin
                    o_prog_rdata <= i_flash_rdata;
                end
            end
            if (prog_rd_ok || prog_wr_ok) begin
                o_flash_addr  <= i_prog.addr;
                o_flash_wdata <= i_prog.wdata;
            end else if (self_req && !self_block) begin
                o_flash_addr  <= i_self.addr;
                o_flash_wdata <= 32'h0000_0000;
            end
            o_self_flash_wr    <= self_req & i_self.wr & ~self_block;
            o_self_flash_erase <= self_req & i_self.erase & ~self_block;
            o_self_blocked     <= self_req & self_block;
        end
    end

    assign o_cfg_active = cfg_active;
    assign o_cfg_ready  = running;
    assign o_debug_en   = code_read_protect ? DEBUG_OFF
                          : word_zero[DEBUG_LSB +: 2];

    // ==========================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_prog_flash_req;
        i_ce && running && (i_prog.wr || (i_prog.rd && !i_prog.id_rd));
    endsequence

    sequence s_self_req;
        i_ce && self_req;
    endsequence

    a_cp_blocks_prog: assert property (
        s_prog_flash_req and code_read_protect
        |=> !o_prog_flash_rd && !o_prog_flash_wr && o_prog_denied)
        else $error("programmer access passed under code protect");

    a_cp_rdata_zero: assert property (
        i_ce && running && i_prog.rd && !i_prog.id_rd && code_read_protect
        |=> o_prog_rvalid && (o_prog_rdata == 32'h0000_0000))
        else $error("flash data leaked under code protect");

    a_id_read_open: assert property (
        i_ce && running && i_prog.rd && i_prog.id_rd
        |=> o_prog_rvalid && (o_prog_rdata == DEVICE_ID))
        else $error("device id read not answered");

    a_debug_forced: assert property (
        code_read_protect |-> (o_debug_en == 2'h3))
        else $error("debugger not disabled under code protect");

    a_boot_wp_block: assert property (
        s_self_req and (self_in_boot && boot_write_protect)
        |=> o_self_blocked && !o_self_flash_wr && !o_self_flash_erase)
        else $error("boot write passed while protected");

    a_pwp_first_page: assert property (
        s_self_req and (i_self.addr == 32'hBD00_0FFF)
        and (page_write_protect_count == 8'hFE)
        |=> o_self_blocked)
        else $error("first protected page not blocked");

    a_pwp_page_edge: assert property (
        s_self_req and (i_self.addr == 32'hBD00_1000)
        and (page_write_protect_count == 8'hFE)
        and !(self_in_boot && boot_write_protect)
        |=> !o_self_blocked)
        else $error("page past region wrongly blocked");

    a_pwp_none: assert property (
        page_write_protect_count == 8'hFF |-> !pwp_enabled)
        else $error("protection active with no pages");

    a_cp_self_ok: assert property (
        s_self_req and i_self.wr and !self_in_boot and !self_in_pwp
        |=> o_self_flash_wr)
        else $error("self write blocked outside protected areas");

    a_lock_holds: assert property (
        i_ce && running && !i_power_on
        |=> ((cfg_active & $past(cfg_locked & cfg_active))
             == $past(cfg_locked & cfg_active)))
        else $error("locked configuration bit changed");

    a_cfg_no_rise: assert property (
        i_ce && cfg_write
        |=> ((cfg_active & ~$past(cfg_active)) == {CFG_BITS{1'b0}}))
        else $error("configuration bit returned to one");

    a_pwp_blocks: assert property (
        s_self_req and self_in_pwp
        |=> o_self_blocked && !o_self_flash_wr && !o_self_flash_erase)
        else $error("self write passed inside protected pages");

    a_prog_rd_pass: assert property (
        s_prog_flash_req and (i_prog.rd && !i_prog.id_rd)
        and !code_read_protect
        |=> o_prog_flash_rd && o_prog_rvalid
            && (o_prog_rdata == $past(i_flash_rdata)))
        else $error("open programmer read not forwarded");

    a_load_reset: assert property (
        i_ce && (state == ST_LOAD)
        |=> running && (cfg_active == $past(i_stored_cfg)))
        else $error("configuration not reloaded after reset");

endmodule

// File: flash_array_model.sv
`timescale 1ns/1ns
// ==========================================
// Flash array beside the protection block
module flash_array_model
    import cfg_protect_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic [WORD_W-1:0] i_rd_addr,
    input  wire logic              i_wr,
    input  wire logic              i_erase,
    input  wire logic [WORD_W-1:0] i_addr,
    input  wire logic [WORD_W-1:0] i_wdata,
    output logic      [WORD_W-1:0] o_rdata
);
    logic [WORD_W-1:0] mem [16];

    initial begin
        for (int k = 0; k < 16; k++) begin
            mem[k] = 32'hA5A5_0000 | 32'(k);
        end
    end

    // Read answer in the request cycle
    assign o_rdata = mem[i_rd_addr[5:2]];

    // Only granted operations change the array
    always @(posedge i_clock) begin
        if (i_erase) begin
            mem[i_addr[5:2]] <= 32'hFFFF_FFFF;
        end else if (i_wr) begin
            mem[i_addr[5:2]] <= i_wdata;
        end
    end
endmodule

// File: tb_config_flash_write_protection.sv
`timescale 1ns/1ns
module tb_config_flash_write_protection
    import cfg_protect_pkg::*;
;
    // ==========================================
    // Signals
    logic                i_clock;
    logic                i_rst;
    logic                i_power_on;
    logic                ce;
    logic [CFG_BITS-1:0] stored;
    cfg_wr_s             cfg_wr;
    prog_req_s           prog;
    self_req_s           self_req;
    logic [WORD_W-1:0]   rdata;
    logic [CFG_BITS-1:0] active;
    logic                ready, mism, fl_rd, fl_wr, denied, rvalid;
    logic [1:0]          dbg;
    logic [WORD_W-1:0]   prdata, faddr, fwdata;
    logic                s_wr, s_er, s_blk;
    int                  n_mismatch = 0;
    int                  total_checks = 0;

    cfg_flash_protect uut (
        .i_clock(i_clock), .i_rst(i_rst), .i_ce(ce),
        .i_power_on(i_power_on), .i_stored_cfg(stored), .i_cfg_wr(cfg_wr),
        .i_prog(prog), .i_flash_rdata(rdata), .i_self(self_req),
        .o_cfg_active(active), .o_cfg_ready(ready),
        .o_cfg_mismatch_rst(mism), .o_debug_en(dbg),
        .o_prog_flash_rd(fl_rd), .o_prog_flash_wr(fl_wr),
        .o_prog_denied(denied), .o_prog_rdata(prdata),
        .o_prog_rvalid(rvalid), .o_flash_addr(faddr),
        .o_flash_wdata(fwdata), .o_self_flash_wr(s_wr),
        .o_self_flash_erase(s_er), .o_self_blocked(s_blk)
    );

    flash_array_model flash (
        .i_clock(i_clock), .i_rd_addr(prog.addr), .i_wr(fl_wr | s_wr),
        .i_erase(s_er), .i_addr(faddr), .i_wdata(fwdata), .o_rdata(rdata)
    );

    // ==========================================
    // Shared tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic boot(input logic [31:0] w0, input logic pwr, input int n);
        int k;
        @(negedge i_clock);
        stored = {96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF, w0};
        i_rst = 1'b1;
        i_power_on = pwr;
        repeat (n) @(negedge i_clock);
        i_rst = 1'b0;
        i_power_on = 1'b0;
        for (k = 0; k < 8 && ready !== 1'b1; k++) @(negedge i_clock);
        if (ready !== 1'b1) begin
            n_mismatch++;
            $display("[ERR] cfg ready expected 1 seen %b", ready);
            finish_test();
        end
        check("active word0", w0, active[31:0]);
        check("active word3", 32'hFFFF_FFFF, active[127:96]);
        check("mismatch rst", 32'h0, mism);
    endtask

    task automatic cfg_write(input logic [1:0] w, input logic [31:0] d);
        @(negedge i_clock);
        cfg_wr = {1'b1, w, d};
        @(negedge i_clock);
        cfg_wr = '0;
    endtask

    task automatic prog_op(input logic [2:0] kind, input logic [31:0] a);
        @(negedge i_clock);
        prog = {kind, a, 32'h5A5A_0001};
        @(negedge i_clock);
        prog = '0;
    endtask

    task automatic self_op(input logic [1:0] we, input logic [31:0] a,
                           input logic blk);
        @(negedge i_clock);
        self_req = {we, a};
        @(negedge i_clock);
        self_req = '0;
        check("self blocked", 32'(blk), 32'(s_blk));
        check("self granted", 32'(!blk), 32'(s_wr | s_er));
    endtask

    // ==========================================
    // Scenarios
    task automatic t_write_once();
        check("debug field", 32'h2, 32'(dbg));
        cfg_write(2'h1, 32'hFFFF_FFF0);
        check("word1 first", 32'hFFFF_FFF0, active[63:32]);
        cfg_write(2'h1, 32'hFFFF_FF00);
        check("word1 more", 32'hFFFF_FF00, active[63:32]);
        cfg_write(2'h1, 32'hFFFF_FFFF);
        check("word1 ones", 32'hFFFF_FF00, active[63:32]);
        boot(32'hFFFF_FFFE, 1'b0, 2);
        check("word1 reload", 32'hFFFF_FFFF, active[63:32]);
        cfg_write(2'h1, 32'hFFFF_FEFE);
        check("word1 locked", 32'hFFFF_FEFF, active[63:32]);
        boot(32'hFFFF_FFFE, 1'b1, 2);
        cfg_write(2'h1, 32'hFFFF_FFFE);
        check("word1 unlock", 32'hFFFF_FFFE, active[63:32]);
    endtask

    task automatic t_pages();
        logic [7:0]  fld [5] = '{8'hFE, 8'hF0, 8'h7F, 8'h00, 8'hFF};
        logic [31:0] span;
        logic [31:0] last;
        for (int i = 0; i < 5; i++) begin
            boot({12'hFFF, fld[i], 12'hFFE}, 1'b0, 2);
            span = {24'h00_0000, ~fld[i]} * PAGE_BYTES;
            if (span > PFLASH_BYTES) span = PFLASH_BYTES;
            last = PFLASH_BASE + span - 32'h1;
            if (span == 32'h0) begin
                self_op(2'b10, PFLASH_BASE, 1'b0);
            end else begin
                self_op(2'b10, last, 1'b1);
                self_op(2'b01, PFLASH_BASE, 1'b1);
                if (last < 32'hBD07_FFFF) begin
                    self_op(2'b01, last + 32'h1, 1'b0);
                end
            end
        end
        prog_op(3'b100, 32'hBD00_0FFC);
        check("prog read ok", 32'h1, 32'(fl_rd & rvalid));
        check("kept content", 32'hA5A5_000F, prdata);
        prog_op(3'b010, PFLASH_BASE);
        check("prog wr ok", 32'h1, 32'(fl_wr & !denied));
        check("flash addr", PFLASH_BASE, faddr);
        check("flash wdata", 32'h5A5A_0001, fwdata);
    endtask

    task automatic t_code_protect();
        boot(32'hEFFF_FFFE, 1'b0, 2);
        check("debug forced", 32'h3, 32'(dbg));
        prog_op(3'b100, 32'hBD00_0FFC);
        check("rd denied", 32'h1, 32'(denied & !fl_rd));
        check("rd data", 32'h0, prdata);
        prog_op(3'b010, PFLASH_BASE);
        check("wr denied", 32'h1, 32'(denied & !fl_wr));
        prog_op(3'b101, 32'h0);
        check("id valid", 32'h1, 32'(rvalid));
        check("id data", DEVICE_ID, prdata);
        self_op(2'b10, PFLASH_BASE, 1'b0);
        check("self addr", PFLASH_BASE, faddr);
    endtask

    task automatic t_boot_wp();
        boot(32'hFEFF_FFFE, 1'b0, 2);
        self_op(2'b10, BFLASH_BASE, 1'b1);
        self_op(2'b01, BFLASH_LAST - 32'h3, 1'b1);
        boot(32'hFFFF_FFFE, 1'b0, 2);
        self_op(2'b10, BFLASH_BASE, 1'b0);
    endtask

    task automatic t_ce_hold();
        @(negedge i_clock);
        ce = 1'b0;
        cfg_wr = {1'b1, 2'h2, 32'h0000_0000};
        self_req = {2'b10, PFLASH_BASE};
        repeat (2) @(negedge i_clock);
        check("ce word2", 32'hFFFF_FFFF, active[95:64]);
        check("ce self", 32'h0, 32'(s_wr));
        cfg_wr = '0;
        self_req = '0;
        ce = 1'b1;
    endtask

    // ==========================================
    // Clock and main sequence
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end

    initial begin
        i_rst = 1'b1;
        i_power_on = 1'b1;
        ce = 1'b1;
        stored = CFG_RESET;
        cfg_wr = '0;
        prog = '0;
        self_req = '0;
        boot(32'hFFFF_FFFE, 1'b1, 16);
        t_write_once();
        t_pages();
        t_code_protect();
        t_boot_wp();
        t_ce_hold();
        check("mismatch end", 32'h0, 32'(mism));
        finish_test();
    end
endmodule
